// ### pkg/cfr_pkg.sv
// Package of constants and types for the overcurrent fault response block.
package cfr_pkg;

   // ----------------------------------------------------------------------
   // Response byte field layout
   // ----------------------------------------------------------------------
   localparam int RESP_MSB  = 7;
   localparam int RESP_LSB  = 6;
   localparam int RETRY_MSB = 5;
   localparam int RETRY_LSB = 3;
   localparam int DELAY_MSB = 2;
   localparam int DELAY_LSB = 0;

   localparam logic [1:0] RESP_CONST_CURRENT = 2'h0;
   localparam logic [1:0] RESP_LIMIT_UV      = 2'h1;
   localparam logic [1:0] RESP_LIMIT_TIMED   = 2'h2;
   localparam logic [1:0] RESP_SHUTDOWN      = 2'h3;

   localparam logic [2:0] RETRY_NONE     = 3'h0;
   localparam logic [2:0] RETRY_FOREVER  = 3'h7;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 25;
   localparam int DELAY_UNIT_NS   = 1000000;
   localparam int DELAY_UNIT_CYC  = DELAY_UNIT_NS / CLK_PERIOD_NS;
   localparam int BUS_QUARTER_NS  = 2500;
   localparam int BUS_QUARTER_CYC = BUS_QUARTER_NS / CLK_PERIOD_NS;

   // ----------------------------------------------------------------------
   // Notice packet and summary status word
   // ----------------------------------------------------------------------
   localparam logic [6:0] HOST_ADDR      = 7'h08;
   localparam int         STATUS_OC_BIT  = 4;
   localparam int         STATUS_OFF_BIT = 6;
   localparam int         N_ASYNC        = 5;

   typedef enum logic [5:0] {
      ST_OFF   = 6'h01,
      ST_RUN   = 6'h02,
      ST_LIMIT = 6'h04,
      ST_WAIT  = 6'h08,
      ST_TRY   = 6'h10,
      ST_LATCH = 6'h20
   } cfr_state_e;

   typedef enum logic [3:0] {
      TX_IDLE  = 4'h1,
      TX_START = 4'h2,
      TX_BIT   = 4'h4,
      TX_STOP  = 4'h8
   } cfr_tx_state_e;

endpackage : cfr_pkg

// ### pkg/cfr_tx_if.sv
// Interface between the fault controller and the notice transmitter.
`timescale 1ns/100ps
interface cfr_tx_if;
   logic        start;
   logic [15:0] word;
   logic [6:0]  dev_addr;
   logic        busy;
   logic        done;
   logic        ok;

   modport ctrl (output start, output word, output dev_addr,
                 input busy, input done, input ok);
   modport tx   (input start, input word, input dev_addr,
                 output busy, output done, output ok);
endinterface : cfr_tx_if

// ### design/cfr_notify_tx.sv
// Two-wire bus master that sends one notice packet to the host.
`timescale 1ns/100ps
module cfr_notify_tx
   import cfr_pkg::*;
(
   input  wire logic clk,
   input  wire logic srst,
   cfr_tx_if.tx      link,
   input  wire logic scl_f,
   input  wire logic sda_f,
   output logic      scl_oe,
   output logic      sda_oe
);

   cfr_tx_state_e st_reg, st_next;
   logic [7:0]  q_cnt_reg, q_cnt_next;
   logic        tick;
   logic [1:0]  ph_reg, ph_next;
   logic [1:0]  byte_reg, byte_next;
   logic [3:0]  bit_reg, bit_next;
   logic [15:0] word_reg, word_next;
   logic [6:0]  addr_reg, addr_next;
   logic        scl_oe_reg, scl_oe_next;
   logic        sda_oe_reg, sda_oe_next;
   logic        done_reg, done_next;
   logic        ok_reg, ok_next;
   logic [7:0]  cur_byte;
   logic        cur_bit;

   assign tick   = (q_cnt_reg == 8'(BUS_QUARTER_CYC - 1));
   assign scl_oe = scl_oe_reg;
   assign sda_oe = sda_oe_reg;
   assign link.busy = (st_reg != TX_IDLE);
   assign link.done = done_reg;
   assign link.ok   = ok_reg;

   always_comb
   begin
      case (byte_reg)
         2'h0:    cur_byte = {HOST_ADDR, 1'b0};
         2'h1:    cur_byte = {addr_reg, 1'b0};
         2'h2:    cur_byte = word_reg[7:0];
         default: cur_byte = word_reg[15:8];
      endcase
      cur_bit = cur_byte[3'(7 - bit_reg[2:0])];
   end

   // ----------------------------------------------------------------------
   // Bit sequencer
   // ----------------------------------------------------------------------
   always_comb
   begin
      st_next     = st_reg;
      q_cnt_next  = tick ? 8'h00 : q_cnt_reg + 8'h01;
      ph_next     = ph_reg;
      byte_next   = byte_reg;
      bit_next    = bit_reg;
      word_next   = word_reg;
      addr_next   = addr_reg;
      scl_oe_next = scl_oe_reg;
      sda_oe_next = sda_oe_reg;
      done_next   = 1'b0;
      ok_next     = ok_reg;
      case (st_reg)
         TX_IDLE:
         begin
            q_cnt_next = 8'h00;
            ph_next    = 2'h0;
            if (link.start && scl_f && sda_f)
            begin
               st_next   = TX_START;
               word_next = link.word;
               addr_next = link.dev_addr;
               byte_next = 2'h0;
               bit_next  = 4'h0;
            end
         end
         TX_START:
            if (tick)
            begin
               ph_next = ph_reg + 2'h1;
               if (ph_reg == 2'h0)
                  sda_oe_next = 1'b1;
               else
               begin
                  scl_oe_next = 1'b1;
                  ph_next     = 2'h0;
                  st_next     = TX_BIT;
               end
            end
         TX_BIT:
            if (tick && (ph_reg != 2'h2 || scl_f))
            begin
               ph_next = ph_reg + 2'h1;
               case (ph_reg)
                  2'h0:    sda_oe_next = (bit_reg == 4'h8) ? 1'b0 : ~cur_bit;
                  2'h1:    scl_oe_next = 1'b0;
                  2'h2:
                     if (bit_reg != 4'h8 && !sda_oe_reg && !sda_f)
                     begin
                        st_next     = TX_IDLE;
                        sda_oe_next = 1'b0;
                        done_next   = 1'b1;
                        ok_next     = 1'b0;
                     end
                     else if (bit_reg == 4'h8 && sda_f)
                     begin
                        ok_next = 1'b0;
                        st_next = TX_STOP;
                        ph_next = 2'h0;
                        scl_oe_next = 1'b1;
                     end
                  default:
                  begin
                     scl_oe_next = 1'b1;
                     bit_next    = bit_reg + 4'h1;
                     if (bit_reg == 4'h8)
                     begin
                        bit_next  = 4'h0;
                        byte_next = byte_reg + 2'h1;
                        if (byte_reg == 2'h3)
                        begin
                           ok_next = 1'b1;
                           st_next = TX_STOP;
                        end
                     end
                  end
               endcase
            end
         TX_STOP:
            if (tick && (ph_reg != 2'h2 || scl_f))
            begin
               ph_next = ph_reg + 2'h1;
               case (ph_reg)
                  2'h0:    sda_oe_next = 1'b1;
                  2'h1:    scl_oe_next = 1'b0;
                  default:
                  begin
                     sda_oe_next = 1'b0;
                     done_next   = 1'b1;
                     st_next     = TX_IDLE;
                  end
               endcase
            end
         default: st_next = TX_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         st_reg     <= TX_IDLE;
         q_cnt_reg  <= 8'h00;
         ph_reg     <= 2'h0;
         byte_reg   <= 2'h0;
         bit_reg    <= 4'h0;
         word_reg   <= 16'h0000;
         addr_reg   <= 7'h00;
         scl_oe_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
         done_reg   <= 1'b0;
         ok_reg     <= 1'b0;
      end
      else
      begin
         st_reg     <= st_next;
         q_cnt_reg  <= q_cnt_next;
         ph_reg     <= ph_next;
         byte_reg   <= byte_next;
         bit_reg    <= bit_next;
         word_reg   <= word_next;
         addr_reg   <= addr_next;
         scl_oe_reg <= scl_oe_next;
         sda_oe_reg <= sda_oe_next;
         done_reg   <= done_next;
         ok_reg     <= ok_next;
      end
   end

endmodule : cfr_notify_tx

// ### design/cfr_fault_ctrl.sv
// Overcurrent fault response, restart policy and host notification.
`timescale 1ns/100ps
// Notes on behaviour
// - Every response sets fault bit and notifies host.
// - Fault bit stays set until explicitly cleared.
// - Code 00 limits current forever.
// - Code 01 limits until voltage drops, then shuts.
// - Code 10 limits for delay, then retry policy.
// - Code 11 shuts down at once, then retry policy.
// - Retry 000 never restarts; stays off.
// - Retry 1..6 attempts, then latched off.
// - Restart starts spaced by delay count units.
// - Retry 111 restarts until commanded off.
// - Delay field counts units for both timings.
// - Only one notification method is used.
// - No repeat notice until host reads status.
// - Device acts as bus master to send notice.
// - Notice data equals summary status word.
// - Shutdown clears by reset, off-on or power.
module cfr_fault_ctrl
   import cfr_pkg::*;
#(
   parameter int unsigned DELAY_UNIT_CYCLES = DELAY_UNIT_CYC
)
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic [7:0]  overcurrent_response_setting,
   input  wire logic        oc_detect,
   input  wire logic        uv_detect,
   input  wire logic        fault_reset_pin,
   input  wire logic        enable_cmd,
   input  wire logic        status_read,
   input  wire logic        status_clear,
   input  wire logic [15:0] other_status,
   input  wire logic [6:0]  device_addr,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             scl_out,
   output logic             scl_oe,
   output logic             sda_out,
   output logic             sda_oe,
   output logic             output_enable,
   output logic             current_limit_en,
   output logic             oc_fault_status,
   output logic [15:0]      status_word
);

   cfr_tx_if tx ();

   logic [N_ASYNC-1:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
   logic               oc_f, uv_f, rst_f, scl_f, sda_f;
   logic               oc_d_reg, rst_d_reg;
   logic [1:0]         resp;
   logic [2:0]         retry, delay;

   assign resp  = overcurrent_response_setting[RESP_MSB:RESP_LSB];
   assign retry = overcurrent_response_setting[RETRY_MSB:RETRY_LSB];
   assign delay = overcurrent_response_setting[DELAY_MSB:DELAY_LSB];
   assign {sda_f, scl_f, rst_f, uv_f, oc_f} = filt_reg;

   // ----------------------------------------------------------------------
   // Input synchronisers; a level counts once stages two and three agree
   // ----------------------------------------------------------------------
   always_comb
   begin
      for (int i = 0; i < N_ASYNC; i++)
         filt_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : filt_reg[i];
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         s1_reg    <= '0;
         s2_reg    <= '0;
         s3_reg    <= '0;
         filt_reg  <= '0;
         oc_d_reg  <= 1'b0;
         rst_d_reg <= 1'b0;
      end
      else
      begin
         s1_reg    <= {sda_in, scl_in, fault_reset_pin, uv_detect, oc_detect};
         s2_reg    <= s1_reg;
         s3_reg    <= s2_reg;
         filt_reg  <= filt_next;
         oc_d_reg  <= oc_f;
         rst_d_reg <= rst_f;
      end
   end

   // ----------------------------------------------------------------------
   // Delay unit divider and unit timer
   // ----------------------------------------------------------------------
   logic [31:0] unit_cnt_reg, unit_cnt_next;
   logic [2:0]  tmr_reg, tmr_next;
   logic        tmr_load, unit_tick;

   assign unit_tick = (unit_cnt_reg == DELAY_UNIT_CYCLES - 1);

   always_comb
   begin
      unit_cnt_next = unit_tick ? 32'h0 : unit_cnt_reg + 32'h1;
      tmr_next      = tmr_reg;
      if (tmr_load)
      begin
         unit_cnt_next = 32'h0;
         tmr_next      = delay;
      end
      else if (unit_tick && tmr_reg != 3'h0)
         tmr_next = tmr_reg - 3'h1;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         unit_cnt_reg <= 32'h0;
         tmr_reg      <= 3'h0;
      end
      else
      begin
         unit_cnt_reg <= unit_cnt_next;
         tmr_reg      <= tmr_next;
      end
   end

   // ----------------------------------------------------------------------
   // Fault response state machine
   // ----------------------------------------------------------------------
   cfr_state_e st_reg, st_next;
   logic [2:0] tries_reg, tries_next;
   logic       out_reg, out_next, lim_reg, lim_next;
   logic       shut, clear_evt, en_d_reg;

   // A reset pulse or an off-to-on command clears a latched shutdown.
   assign clear_evt = (rst_f && !rst_d_reg) || (enable_cmd && !en_d_reg);

   always_comb
   begin
      st_next    = st_reg;
      tries_next = tries_reg;
      out_next   = out_reg;
      lim_next   = lim_reg;
      tmr_load   = 1'b0;
      shut       = 1'b0;
      case (st_reg)
         ST_OFF:
         begin
            st_next  = ST_RUN;
            out_next = 1'b1;
         end
         ST_RUN, ST_TRY:
            if (oc_f)
            begin
               if (resp == RESP_SHUTDOWN)
                  shut = 1'b1;
               else
               begin
                  st_next  = ST_LIMIT;
                  lim_next = 1'b1;
                  tmr_load = 1'b1;
               end
            end
            else if (st_reg == ST_TRY && tmr_reg == 3'h0)
            begin
               st_next    = ST_RUN;
               tries_next = 3'h0;
            end
         ST_LIMIT:
            if (!oc_f)
            begin
               st_next  = ST_RUN;
               lim_next = 1'b0;
            end
            else if (resp == RESP_LIMIT_UV && uv_f)
               shut = 1'b1;
            else if (resp == RESP_LIMIT_TIMED && tmr_reg == 3'h0)
               shut = 1'b1;
            else if (resp == RESP_SHUTDOWN)
               shut = 1'b1;
         ST_WAIT:
            if (tmr_reg == 3'h0)
            begin
               st_next  = ST_TRY;
               out_next = 1'b1;
               tmr_load = 1'b1;
               if (retry != RETRY_FOREVER)
                  tries_next = tries_reg + 3'h1;
            end
         ST_LATCH:
            out_next = 1'b0;
         default:
         begin
            st_next  = ST_OFF;
            out_next = 1'b0;
         end
      endcase
      if (shut)
      begin
         out_next = 1'b0;
         lim_next = 1'b0;
         if (retry == RETRY_NONE)
            st_next = ST_LATCH;
         else if (retry != RETRY_FOREVER && tries_reg >= retry)
            st_next = ST_LATCH;
         else
         begin
            st_next  = ST_WAIT;
            tmr_load = 1'b1;
         end
      end
      if (!enable_cmd)
      begin
         st_next    = ST_OFF;
         out_next   = 1'b0;
         lim_next   = 1'b0;
         tries_next = 3'h0;
      end
      else if (clear_evt && (st_reg == ST_LATCH || st_reg == ST_WAIT))
      begin
         st_next    = ST_RUN;
         out_next   = 1'b1;
         tries_next = 3'h0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         st_reg    <= ST_OFF;
         tries_reg <= 3'h0;
         out_reg   <= 1'b0;
         lim_reg   <= 1'b0;
         en_d_reg  <= 1'b0;
      end
      else
      begin
         st_reg    <= st_next;
         tries_reg <= tries_next;
         out_reg   <= out_next;
         lim_reg   <= lim_next;
         en_d_reg  <= enable_cmd;
      end
   end

   // ----------------------------------------------------------------------
   // Fault status and direct notification
   // ----------------------------------------------------------------------
   logic        flt_reg, flt_next, told_reg, told_next;
   logic        pend_reg, pend_next, go_reg, go_next;
   logic [15:0] sw_reg, sw_next;

   always_comb
   begin
      // Hardware set wins over a clear in the same cycle.
      flt_next  = (flt_reg && !status_clear) || oc_f;
      told_next = told_reg && !status_read;
      pend_next = pend_reg;
      go_next   = 1'b0;
      if (tx.done && tx.ok)
         pend_next = 1'b0;
      if (oc_f && !oc_d_reg && (!told_reg || status_read))
      begin
         pend_next = 1'b1;
         told_next = 1'b1;
      end
      if (pend_reg && !tx.busy && !go_reg && !(tx.done && tx.ok))
         go_next = 1'b1;
      sw_next = other_status;
      sw_next[STATUS_OC_BIT]  = flt_next;
      sw_next[STATUS_OFF_BIT] = !out_next;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         flt_reg  <= 1'b0;
         told_reg <= 1'b0;
         pend_reg <= 1'b0;
         go_reg   <= 1'b0;
         sw_reg   <= 16'h0000;
      end
      else
      begin
         flt_reg  <= flt_next;
         told_reg <= told_next;
         pend_reg <= pend_next;
         go_reg   <= go_next;
         sw_reg   <= sw_next;
      end
   end

   // Only the direct bus-master notice is built; no alert line exists.
   assign tx.start    = go_reg;
   assign tx.word     = sw_reg;
   assign tx.dev_addr = device_addr;

   cfr_notify_tx u_tx (
      .clk    (clk),
      .srst   (srst),
      .link   (tx),
      .scl_f  (scl_f),
      .sda_f  (sda_f),
      .scl_oe (scl_oe),
      .sda_oe (sda_oe)
   );

   assign scl_out          = 1'b0;
   assign sda_out          = 1'b0;
   assign output_enable    = out_reg;
   assign current_limit_en = lim_reg;
   assign oc_fault_status  = flt_reg;
   assign status_word      = sw_reg;

endmodule : cfr_fault_ctrl

// ### verification/cfr_fault_ctrl_chk.sv
// Port-level checks of the overcurrent fault response block.
`timescale 1ns/100ps
module cfr_fault_ctrl_chk
   import cfr_pkg::*;
#(
   parameter int unsigned DELAY_UNIT_CYCLES = DELAY_UNIT_CYC
)
(
   input wire logic       clk,
   input wire logic       srst,
   input wire logic [7:0] overcurrent_response_setting,
   input wire logic       oc_detect,
   input wire logic       uv_detect,
   input wire logic       fault_reset_pin,
   input wire logic       enable_cmd,
   input wire logic       status_clear,
   input wire logic       scl_out,
   input wire logic       sda_out,
   input wire logic       output_enable,
   input wire logic       current_limit_en,
   input wire logic       oc_fault_status
);
   logic [1:0] resp;
   logic [2:0] retry;
   logic [2:0] dly;
   int         lim_reg;
   int         lim_next;

   assign resp  = overcurrent_response_setting[RESP_MSB:RESP_LSB];
   assign retry = overcurrent_response_setting[RETRY_MSB:RETRY_LSB];
   assign dly   = overcurrent_response_setting[DELAY_MSB:DELAY_LSB];

   // Length of the current limiting spell in progress.
   always_comb
      lim_next = current_limit_en ? lim_reg + 1 : 0;
   always_ff @(posedge clk)
      lim_reg <= srst ? 0 : lim_next;

   default clocking @(posedge clk); endclocking
   default disable iff (srst);

   sequence s_oc_held;
      oc_detect [*8];
   endsequence
   sequence s_uv_in_limit;
      resp == RESP_LIMIT_UV && dly != 3'h0 && current_limit_en
      ##1 (resp == RESP_LIMIT_UV && uv_detect) [*8];
   endsequence
   sequence s_settled_on;
      enable_cmd [*3];
   endsequence

   chk_oc_sets_bit: assert property (
      s_oc_held |-> oc_fault_status)
      else $error("fault bit not set");
   chk_bit_sticky: assert property (
      oc_fault_status && !status_clear |=> oc_fault_status)
      else $error("fault bit dropped");
   chk_const_on: assert property (
      resp == RESP_CONST_CURRENT && current_limit_en && enable_cmd
      |=> output_enable)
      else $error("limiting output switched off");
   chk_limit_powered: assert property (
      current_limit_en |-> output_enable)
      else $error("limiting with output off");
   chk_uv_shut: assert property (
      s_uv_in_limit |-> !output_enable)
      else $error("no shutdown on low voltage");
   chk_timed_bound: assert property (
      resp == RESP_LIMIT_TIMED
      |-> lim_reg <= (dly + 1) * DELAY_UNIT_CYCLES + 8)
      else $error("timed limiting too long");
   chk_shut_fast: assert property (
      (resp == RESP_SHUTDOWN && oc_detect) [*8] ##0 output_enable
      |=> !output_enable)
      else $error("output kept on in shutdown mode");
   chk_no_restart: assert property (
      s_settled_on ##0 (retry == RETRY_NONE && !fault_reset_pin
      && !output_enable) |=> !output_enable)
      else $error("restart with retry disabled");
   chk_drive_low: assert property (
      !scl_out && !sda_out)
      else $error("bus wire driven high");
   chk_cmd_off: assert property (
      !enable_cmd [*3] |-> !output_enable && !current_limit_en)
      else $error("output on while commanded off");
endmodule : cfr_fault_ctrl_chk

// ### verification/cfr_host_model.sv
// Host bus controller that takes in and acknowledges notice packets.
`timescale 1ns/100ps
module cfr_host_model
(
   input  wire logic   scl,
   input  wire logic   sda,
   output logic        sda_oe,
   output logic [31:0] rx_data,
   output int          rx_count
);
   int         bit_cnt;
   int         byte_cnt;
   logic [7:0] shift;

   initial
   begin
      sda_oe   = 1'b0;
      rx_data  = 32'h0;
      rx_count = 0;
      bit_cnt  = 0;
      byte_cnt = 0;
      shift    = 8'h0;
   end

   // A rising data line under a high clock line closes a packet.
   always @(posedge sda)
      if (scl === 1'b1 && byte_cnt > 0)
      begin
         rx_count++;
         byte_cnt = 0;
      end

   // A falling data line under a high clock line opens a packet.
   always @(negedge sda)
      if (scl === 1'b1)
         bit_cnt = 0;

   always @(posedge scl)
   begin
      if (bit_cnt < 8)
         shift = {shift[6:0], sda};
      bit_cnt++;
   end

   // The ninth clock of each byte carries the acknowledge.
   always @(negedge scl)
      if (bit_cnt == 8)
         sda_oe <= 1'b1;
      else if (bit_cnt == 9)
      begin
         sda_oe  <= 1'b0;
         bit_cnt = 0;
         rx_data <= {rx_data[23:0], shift};
         byte_cnt++;
      end
endmodule : cfr_host_model

// ### verification/cfr_fault_ctrl_bench.sv
// Self-checking bench for the overcurrent fault response block.
`timescale 1ns/100ps
module cfr_fault_ctrl_bench;
   import cfr_pkg::*;

   localparam int unsigned UNIT = 8;

   logic        clk, srst, oc_detect, uv_detect, fault_reset_pin;
   logic        enable_cmd, status_read, status_clear;
   logic [7:0]  cfg;
   logic [15:0] other_status, status_word;
   logic [6:0]  device_addr;
   logic        scl_out, scl_oe, sda_out, sda_oe, host_oe, scl_w, sda_w;
   logic        output_enable, current_limit_en, oc_fault_status;
   logic [31:0] rx_data;
   int          rx_count, bad_count, samples_checked;

   // Open-drain wires with pull-ups; any driver pulls them low.
   assign scl_w = !scl_oe;
   assign sda_w = !(sda_oe || host_oe);

   cfr_fault_ctrl #(
      .DELAY_UNIT_CYCLES(UNIT)
   ) u_cfr_fault_ctrl (
      .clk(clk), .srst(srst), .overcurrent_response_setting(cfg),
      .oc_detect(oc_detect), .uv_detect(uv_detect),
      .fault_reset_pin(fault_reset_pin), .enable_cmd(enable_cmd),
      .status_read(status_read), .status_clear(status_clear),
      .other_status(other_status), .device_addr(device_addr),
      .scl_in(scl_w), .sda_in(sda_w), .scl_out(scl_out),
      .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
      .output_enable(output_enable), .current_limit_en(current_limit_en),
      .oc_fault_status(oc_fault_status), .status_word(status_word)
   );

   cfr_host_model u_cfr_host_model (
      .scl(scl_w), .sda(sda_w), .sda_oe(host_oe),
      .rx_data(rx_data), .rx_count(rx_count)
   );

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = !clk;
   end

   task automatic tick(int n);
      repeat (n) @(posedge clk);
   endtask : tick

   task automatic check(logic [31:0] got, logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t: got %h, want %h", $time, got, exp);
      end
   endtask : check

   task automatic final_report;
      $display("compared %0d, mismatched %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : final_report

   task automatic wait_rx(int n, int lim);
      repeat (lim)
         if (rx_count < n)
            @(posedge clk);
      #1;
   endtask : wait_rx

   task automatic toggle_on;
      @(posedge clk) enable_cmd <= 1'b0;
      tick(8);
      enable_cmd <= 1'b1;
      tick(6);
      #1 check(output_enable, 1'b1);
   endtask : toggle_on

   task automatic t_const;
      logic [15:0] w;
      logic [31:0] pkt;
      w = other_status | (16'h1 << STATUS_OC_BIT);
      pkt = {HOST_ADDR, 1'b0, device_addr, 1'b0, w[7:0], w[15:8]};
      @(posedge clk);
      cfg       <= {RESP_CONST_CURRENT, RETRY_NONE, 3'h1};
      oc_detect <= 1'b1;
      tick(40);
      #1 check(current_limit_en, 1'b1);
      check(output_enable, 1'b1);
      check(oc_fault_status, 1'b1);
      check(status_word, w);
      @(posedge clk) oc_detect <= 1'b0;
      wait_rx(1, 20000);
      check(rx_count, 1);
      check(rx_data, pkt);
      check(oc_fault_status, 1'b1);
      @(posedge clk) status_clear <= 1'b1;
      @(posedge clk) status_clear <= 1'b0;
      tick(2);
      #1 check(oc_fault_status, 1'b0);
   endtask : t_const

   task automatic t_notify;
      @(posedge clk) oc_detect <= 1'b1;
      tick(20);
      oc_detect <= 1'b0;
      wait_rx(2, 17000);
      check(rx_count, 1);
      @(posedge clk) status_read <= 1'b1;
      @(posedge clk);
      status_read <= 1'b0;
      oc_detect   <= 1'b1;
      tick(20);
      oc_detect <= 1'b0;
      wait_rx(2, 20000);
      check(rx_count, 2);
   endtask : t_notify

   task automatic t_uv;
      @(posedge clk);
      cfg       <= {RESP_LIMIT_UV, RETRY_NONE, 3'h1};
      oc_detect <= 1'b1;
      tick(20);
      #1 check(current_limit_en, 1'b1);
      @(posedge clk) uv_detect <= 1'b1;
      tick(20);
      #1 check(output_enable, 1'b0);
      tick(60);
      #1 check(output_enable, 1'b0);
      @(posedge clk);
      oc_detect <= 1'b0;
      uv_detect <= 1'b0;
      toggle_on;
   endtask : t_uv

   task automatic t_timed;
      @(posedge clk);
      cfg       <= {RESP_LIMIT_TIMED, RETRY_NONE, 3'h2};
      oc_detect <= 1'b1;
      tick(14);
      #1 check(current_limit_en, 1'b1);
      check(output_enable, 1'b1);
      tick(20);
      #1 check(output_enable, 1'b0);
      @(posedge clk) oc_detect <= 1'b0;
      toggle_on;
   endtask : t_timed

   task automatic t_retry;
      logic [2:0] tries [3] = '{3'h1, 3'h6, RETRY_FOREVER};
      int         n;
      int         short_gaps;
      int         off_run;
      logic       oe_prev;
      foreach (tries[k])
      begin
         @(posedge clk);
         cfg        <= {RESP_SHUTDOWN, tries[k], 3'h1};
         oc_detect  <= 1'b1;
         n          = 0;
         short_gaps = 0;
         off_run    = 0;
         oe_prev    = 1'b1;
         repeat (400)
         begin
            @(posedge clk);
            #1;
            if (output_enable && !oe_prev)
            begin
               n++;
               if (off_run < UNIT - 1)
                  short_gaps++;
            end
            off_run = output_enable ? 0 : off_run + 1;
            oe_prev = output_enable;
         end
         check(short_gaps, 0);
         if (tries[k] == RETRY_FOREVER)
            check(n > 6, 1'b1);
         else
            check(n, tries[k]);
         @(posedge clk) oc_detect <= 1'b0;
         tick(10);
         fault_reset_pin <= 1'b1;
         tick(10);
         fault_reset_pin <= 1'b0;
         tick(6);
         #1 check(output_enable, 1'b1);
      end
   endtask : t_retry

   initial
   begin
      srst            = 1'b1;
      cfg             = 8'h00;
      oc_detect       = 1'b0;
      uv_detect       = 1'b0;
      fault_reset_pin = 1'b0;
      enable_cmd      = 1'b1;
      status_read     = 1'b0;
      status_clear    = 1'b0;
      other_status    = 16'h8001;
      device_addr     = 7'h2a;
      tick(5);
      srst <= 1'b0;
      tick(8);
      t_const;
      t_notify;
      t_uv;
      t_timed;
      t_retry;
      final_report;
   end

   initial
   begin
      tick(90000);
      bad_count++;
      final_report;
   end
endmodule : cfr_fault_ctrl_bench

bind cfr_fault_ctrl cfr_fault_ctrl_chk #(
   .DELAY_UNIT_CYCLES(DELAY_UNIT_CYCLES)
) u_cfr_fault_ctrl_chk (
   .clk, .srst, .overcurrent_response_setting, .oc_detect, .uv_detect,
   .fault_reset_pin, .enable_cmd, .status_clear, .scl_out, .sda_out,
   .output_enable, .current_limit_en, .oc_fault_status
);
